// *** hw/tone_pkg.sv ***
// Function
// RL1: External mode: keying waveform sets tone timing.
// RL2: External mode: start 1 us, stop 60 us.
// RL3: Host sets both mode bits before keying.
// RL4: Envelope mode: internal tone while keying high.
// RL5: Envelope: on after 6 us, off 15-60 us.
// RL6: Continuous tone: keying high, select zero.
// RL7: Host keeps low-drop zero while tone active.
// RL8: Low-drop set only when no tone needed.
// RL9: Host brackets each transmission with tone bit.
// RL10: Filter bypass driven only while transmitting.
// RL11: Received bursts shown on detected data output.
// RL12: Eight diagnostic flags in two status registers.
// RL13: Latched flags clear after cause gone, read.
// RL14: Four-bit output level field in data one.
// RL15: Fault pin low while latched flag set.
// RL16: Tone presence flag high while tone sensed.
// RL17: Lockout ignores commands, zeroes data registers.
// RL18: Read clears latched flag only if cause absent.
// RL19: Keying input synchronised before any use.
`default_nettype none
package tone_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_NS = 20;
  localparam int TONE_HZ = 22_000;
  localparam int HALF_CYC = CLK_HZ / (2 * TONE_HZ);
  localparam int EXT_ON_NS = 1_000;
  localparam int EXT_OFF_NS = 60_000;
  localparam int ENV_ON_NS = 6_000;
  localparam int ENV_OFF_NS = 15_000;
  localparam int DET_HOLD_NS = 60_000;
  localparam int EXT_ON_CYC = (EXT_ON_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXT_OFF_CYC = (EXT_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int ENV_ON_CYC = (ENV_ON_NS + CLK_NS - 1) / CLK_NS;
  localparam int ENV_OFF_CYC = (ENV_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int DET_HOLD_CYC = (DET_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 12;
  // ****************************************
  // Device registers
  // ****************************************
  localparam logic [1:0] DEV_DATA1 = 2'h0;
  localparam logic [1:0] DEV_DATA2 = 2'h1;
  localparam logic [1:0] DEV_STAT1 = 2'h2;
  localparam logic [1:0] DEV_STAT2 = 2'h3;
  localparam int VSEL_MSB = 3;
  localparam int D2_TONE_ON = 0;
  localparam int D2_EXT_SEL = 1;
  localparam int D2_LOW_DROP = 2;
  localparam logic [7:0] DEV_RESET = 8'h00;
  // ****************************************
  // Host APB registers
  // ****************************************
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_KEY = 8'h08;
  localparam logic [7:0] OFF_IRQ_ST = 8'h0C;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN = 8'h14;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_READ = 10;
  localparam int STAT_BUSY = 0;
  localparam int STAT_FAULT = 1;
  localparam int STAT_DDATA = 2;
  localparam int STAT_RD_LSB = 8;
  localparam int KEY_LEVEL = 0;
  localparam int KEY_SQUARE = 1;
  localparam int IRQ_N = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_DDATA = 2;
  typedef enum logic [3:0] {
    TS_IDLE = 4'h1,
    TS_START = 4'h2,
    TS_ON = 4'h4,
    TS_STOP = 4'h8
  } tone_state_t;
  typedef enum logic [1:0] {
    HS_IDLE = 2'h1,
    HS_WAIT = 2'h2
  } host_state_t;
endpackage
`default_nettype wire

// *** hw/tone_if.sv ***
`default_nettype none
interface tone_if;
  logic tone_keying_input;
  logic reg_wr;
  logic reg_rd;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_ack;
  logic fault_pin_o;
  logic fault_pin_oe;
  logic fault_pin_level;
  logic detected_data_output;
  // The fault line is open drain with a pull-up.
  assign fault_pin_level = fault_pin_oe ? fault_pin_o : 1'b1;
  modport dev (
    input tone_keying_input, reg_wr, reg_rd, reg_addr, reg_wdata, fault_pin_level,
    output reg_rdata, reg_ack, fault_pin_o, fault_pin_oe, detected_data_output
  );
  modport host (
    output tone_keying_input, reg_wr, reg_rd, reg_addr, reg_wdata,
    input reg_rdata, reg_ack, fault_pin_level, detected_data_output
  );
endinterface
`default_nettype wire

// *** hw/level_sync.sv ***
`default_nettype none
module level_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] d,
  output logic [1:0] q
);
  logic [1:0] meta_r;
  // Only the second stage is read; the first may be metastable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 2'h0;
      q <= 2'h0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** hw/tone_device.sv ***
// The APB slave port and the register addresses were left to the implementer.
`default_nettype none
module tone_device
  import tone_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  tone_if.dev link,
  input wire logic tone_sense_input,
  input wire logic overload_cause,
  input wire logic overtemp_cause,
  input wire logic power_bad_cause,
  input wire logic output_low_cause,
  input wire logic tone_quality_cause,
  input wire logic min_load_cause,
  input wire logic pulldown_oc_cause,
  input wire logic uvlo,
  output logic tone_out,
  output logic tone_active,
  output logic filter_bypass_drive,
  output logic [3:0] vout_sel,
  output logic low_drop_select
);
  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [1:0] sync_q;
  logic key_s;
  logic sense_s;
  logic key_d_r;
  logic sense_d_r;
  logic key_edge;
  logic sense_rise;

  level_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({tone_sense_input, link.tone_keying_input}),
    .q(sync_q)
  ); // [RL19]

  assign key_s = sync_q[0];
  assign sense_s = sync_q[1];
  assign key_edge = key_s ^ key_d_r;
  assign sense_rise = sense_s & ~sense_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_d_r <= 1'b0;
      sense_d_r <= 1'b0;
    end else begin
      key_d_r <= key_s;
      sense_d_r <= sense_s;
    end
  end

  // ****************************************
  // Data registers
  // ****************************************
  logic ten_r;
  logic ext_r;
  logic stat1_rd;

  assign stat1_rd = link.reg_rd & (link.reg_addr == DEV_STAT1) & ~uvlo;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vout_sel <= DEV_RESET[VSEL_MSB:0];
      ten_r <= 1'b0;
      ext_r <= 1'b0;
      low_drop_select <= 1'b0;
    end else if (uvlo) begin
      vout_sel <= DEV_RESET[VSEL_MSB:0]; // [RL17]
      ten_r <= 1'b0;
      ext_r <= 1'b0;
      low_drop_select <= 1'b0;
    end else if (link.reg_wr) begin
      if (link.reg_addr == DEV_DATA1) begin
        vout_sel <= link.reg_wdata[VSEL_MSB:0]; // [RL14]
      end
      if (link.reg_addr == DEV_DATA2) begin
        ten_r <= link.reg_wdata[D2_TONE_ON];
        ext_r <= link.reg_wdata[D2_EXT_SEL];
        low_drop_select <= link.reg_wdata[D2_LOW_DROP];
      end
    end
  end

  // ****************************************
  // Diagnostics
  // ****************************************
  logic [2:0] latch_r;
  logic [2:0] cause;
  logic [3:0] live_r;
  logic tone_presence_flag_r;
  logic [CNT_W-1:0] det_cnt_r;

  assign cause = {power_bad_cause, overtemp_cause, overload_cause};

  // A persisting cause wins over the read, so the flag stays set.
  for (genvar i = 0; i < 3; i++) begin : g_latch
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        latch_r[i] <= 1'b0;
      end else begin
        latch_r[i] <= cause[i] | (latch_r[i] & ~stat1_rd); // [RL13] [RL18]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_r <= 4'h0;
    end else begin
      live_r <= {pulldown_oc_cause, min_load_cause, tone_quality_cause, output_low_cause}; // [RL12]
    end
  end

  // Presence is held one hold window past the last sensed rising edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_cnt_r <= '0;
      tone_presence_flag_r <= 1'b0;
    end else begin
      if (sense_rise) begin
        det_cnt_r <= CNT_W'(DET_HOLD_CYC - 1);
      end else if (det_cnt_r != '0) begin
        det_cnt_r <= det_cnt_r - 1'b1;
      end
      tone_presence_flag_r <= sense_rise | (det_cnt_r != '0); // [RL16]
    end
  end

  assign link.detected_data_output = tone_presence_flag_r; // [RL11]

  logic fault_oe_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_oe_r <= 1'b0;
    end else begin
      fault_oe_r <= |latch_r; // [RL15]
    end
  end

  assign link.fault_pin_o = 1'b0;
  assign link.fault_pin_oe = fault_oe_r;

  // ****************************************
  // Register read path
  // ****************************************
  logic [7:0] stat1;
  logic [7:0] stat2;
  logic [7:0] rd_mux;
  logic [7:0] rdata_r;
  logic ack_r;

  assign stat1 = {4'h0, latch_r[2], live_r[0], latch_r[1], latch_r[0]}; // [RL12]
  assign stat2 = {4'h0, tone_presence_flag_r, live_r[3], live_r[2], live_r[1]};

  always_comb begin
    unique case (link.reg_addr)
      DEV_DATA1: rd_mux = {4'h0, vout_sel};
      DEV_DATA2: rd_mux = {5'h00, low_drop_select, ext_r, ten_r};
      DEV_STAT1: rd_mux = stat1;
      DEV_STAT2: rd_mux = stat2;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ack_r <= link.reg_wr | link.reg_rd;
      rdata_r <= (link.reg_rd & ~uvlo) ? rd_mux : 8'h00;
    end
  end

  assign link.reg_ack = ack_r;
  assign link.reg_rdata = rdata_r;

  // ****************************************
  // Internal tone generator
  // ****************************************
  logic [CNT_W-1:0] half_cnt_r;
  logic gen_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt_r <= '0;
      gen_r <= 1'b0;
    end else if (half_cnt_r == CNT_W'(HALF_CYC - 1)) begin
      half_cnt_r <= '0;
      gen_r <= ~gen_r;
    end else begin
      half_cnt_r <= half_cnt_r + 1'b1;
    end
  end

  // ****************************************
  // Tone keying
  // ****************************************
  tone_state_t st_r;
  logic [CNT_W-1:0] cnt_r;
  logic key_live;

  // External mode is alive on toggling, envelope mode on the level.
  assign key_live = ext_r ? key_edge : key_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= TS_IDLE;
      cnt_r <= '0;
    end else if (!ten_r) begin
      st_r <= TS_IDLE; // [RL6]
    end else begin
      unique case (st_r)
        TS_IDLE: begin
          if (key_live) begin
            st_r <= TS_START;
            cnt_r <= ext_r ? CNT_W'(EXT_ON_CYC - 1) : CNT_W'(ENV_ON_CYC - 1); // [RL2] [RL5]
          end
        end
        TS_START: begin
          if (cnt_r == '0) begin
            st_r <= TS_ON;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        TS_ON: begin
          if (!key_live) begin
            st_r <= TS_STOP;
            cnt_r <= ext_r ? CNT_W'(EXT_OFF_CYC - 1) : CNT_W'(ENV_OFF_CYC - 1); // [RL2] [RL5]
          end
        end
        TS_STOP: begin
          if (key_live) begin
            st_r <= TS_ON;
          end else if (cnt_r == '0) begin
            st_r <= TS_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: st_r <= TS_IDLE;
      endcase
    end
  end

  logic sending;

  assign sending = (st_r == TS_ON) | (st_r == TS_STOP);

  // In external mode only edges and amplitude are ours, timing is the key's.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_out <= 1'b0;
      tone_active <= 1'b0;
      filter_bypass_drive <= 1'b0;
    end else begin
      tone_out <= sending & (ext_r ? key_s : gen_r); // [RL1] [RL4]
      tone_active <= sending;
      filter_bypass_drive <= sending; // [RL10]
    end
  end
endmodule
`default_nettype wire

// *** hw/tone_host.sv ***
`default_nettype none
module tone_host
  import tone_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  tone_if.host link
);
  // ****************************************
  // APB slave
  // ****************************************
  logic acc;
  logic wr_go;
  logic mapped;
  logic [31:0] rd_mux;
  host_state_t hs_r;
  logic [7:0] last_rd_r;
  logic [1:0] key_r;
  logic [IRQ_N-1:0] irq_st_r;
  logic [IRQ_N-1:0] irq_en_r;

  assign acc = psel & penable & ~pready;
  // Writes land on the edge where the master sees pready.
  assign wr_go = psel & penable & pready & pwrite & ~pslverr;
  assign mapped = (paddr == OFF_CMD) | (paddr == OFF_STAT) | (paddr == OFF_KEY)
                | (paddr == OFF_IRQ_ST) | (paddr == OFF_IRQ_CLR) | (paddr == OFF_IRQ_EN);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == OFF_STAT) begin
      rd_mux[STAT_BUSY] = (hs_r == HS_WAIT);
      rd_mux[STAT_FAULT] = link.fault_pin_level;
      rd_mux[STAT_DDATA] = link.detected_data_output;
      rd_mux[STAT_RD_LSB +: 8] = last_rd_r;
    end else if (paddr == OFF_KEY) begin
      rd_mux[1:0] = key_r;
    end else if (paddr == OFF_IRQ_ST) begin
      rd_mux[IRQ_N-1:0] = irq_st_r;
    end else if (paddr == OFF_IRQ_EN) begin
      rd_mux[IRQ_N-1:0] = irq_en_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc & ~mapped;
      prdata <= (acc & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************
  // Device access
  // ****************************************
  logic shadow_ten_r;
  logic shadow_ext_r;
  logic done_ev;
  logic [7:0] wdata_fix;

  // Low drop is masked whenever the same write turns the tone on.
  always_comb begin
    wdata_fix = pwdata[7:0];
    if (pwdata[CMD_ADDR_LSB +: 2] == DEV_DATA2 && pwdata[D2_TONE_ON]) begin
      wdata_fix[D2_LOW_DROP] = 1'b0; // [RL7] [RL8]
    end
  end

  assign done_ev = (hs_r == HS_WAIT) & link.reg_ack;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_r <= HS_IDLE;
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      link.reg_addr <= 2'h0;
      link.reg_wdata <= 8'h00;
      last_rd_r <= 8'h00;
      shadow_ten_r <= 1'b0;
      shadow_ext_r <= 1'b0;
    end else begin
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      unique case (hs_r)
        HS_IDLE: begin
          if (wr_go && paddr == OFF_CMD) begin
            hs_r <= HS_WAIT;
            link.reg_addr <= pwdata[CMD_ADDR_LSB +: 2];
            link.reg_wdata <= wdata_fix;
            link.reg_rd <= pwdata[CMD_READ];
            link.reg_wr <= ~pwdata[CMD_READ];
          end
        end
        HS_WAIT: begin
          if (link.reg_ack) begin
            hs_r <= HS_IDLE;
            last_rd_r <= link.reg_rdata;
            if (!link.reg_rd && link.reg_addr == DEV_DATA2) begin
              shadow_ten_r <= link.reg_wdata[D2_TONE_ON];
              shadow_ext_r <= link.reg_wdata[D2_EXT_SEL];
            end
          end
        end
        default: hs_r <= HS_IDLE;
      endcase
    end
  end

  // ****************************************
  // Keying source
  // ****************************************
  logic [CNT_W-1:0] sq_cnt_r;
  logic sq_r;
  logic key_out_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_r <= 2'h0;
      sq_cnt_r <= '0;
      sq_r <= 1'b0;
      key_out_r <= 1'b0;
    end else begin
      if (wr_go && paddr == OFF_KEY) begin
        key_r <= pwdata[1:0];
      end
      if (sq_cnt_r == CNT_W'(HALF_CYC - 1)) begin
        sq_cnt_r <= '0;
        sq_r <= ~sq_r;
      end else begin
        sq_cnt_r <= sq_cnt_r + 1'b1;
      end
      // The square wave is only sent once both mode bits are in place.
      if (key_r[KEY_SQUARE] && shadow_ten_r && shadow_ext_r) begin
        key_out_r <= sq_r; // [RL3]
      end else begin
        key_out_r <= key_r[KEY_LEVEL]; // [RL6]
      end
    end
  end

  assign link.tone_keying_input = key_out_r;

  // ****************************************
  // Interrupts
  // ****************************************
  logic fault_d_r;
  logic dd_d_r;
  logic [IRQ_N-1:0] ev;

  assign ev[IRQ_DONE] = done_ev;
  assign ev[IRQ_FAULT] = fault_d_r & ~link.fault_pin_level;
  assign ev[IRQ_DDATA] = link.detected_data_output & ~dd_d_r;

  for (genvar i = 0; i < IRQ_N; i++) begin : g_irq
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        irq_st_r[i] <= 1'b0;
      end else begin
        irq_st_r[i] <= ev[i] | (irq_st_r[i] & ~(wr_go & (paddr == OFF_IRQ_CLR) & pwdata[i]));
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_d_r <= 1'b1;
      dd_d_r <= 1'b0;
      irq_en_r <= '0;
      irq <= 1'b0;
    end else begin
      fault_d_r <= link.fault_pin_level;
      dd_d_r <= link.detected_data_output;
      if (wr_go && paddr == OFF_IRQ_EN) begin
        irq_en_r <= pwdata[IRQ_N-1:0];
      end
      irq <= |(irq_st_r & irq_en_r);
    end
  end
endmodule
`default_nettype wire

// *** bench/tone_checker.sv ***
`default_nettype none
module tone_checker
  import tone_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tone_keying_input,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic fault_pin_o,
  input wire logic fault_pin_oe,
  input wire logic fault_pin_level,
  input wire logic detected_data_output
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req;
  logic st_rd;
  assign req = reg_wr | reg_rd;
  assign st_rd = reg_rd & (reg_addr == DEV_STAT1);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****************************************
  // Register port and fault line
  // ****************************************
  property p_ack;
    req |=> reg_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("request not acknowledged");
  property p_single;
    req |=> !req;
  endproperty
  a_single: assert property (p_single) else $error("request too long");
  property p_hold;
    req |=> $stable(reg_addr) && $stable(reg_wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("request fields moved");
  property p_top;
    reg_ack |-> reg_rdata[7:4] == 4'h0;
  endproperty
  a_top: assert property (p_top) else $error("upper read bits set");
  property p_pin;
    fault_pin_oe |-> !fault_pin_level && !fault_pin_o;
  endproperty
  a_pin: assert property (p_pin) else $error("fault line not pulled low");
  // A read clears the flag, so the pin drops two edges later.
  property p_latch;
    fault_pin_oe && !st_rd && !$past(st_rd) |=> fault_pin_oe;
  endproperty
  a_latch: assert property (p_latch) else $error("fault released early");
  property p_free;
    $fell(fault_pin_oe) |-> $past(st_rd, 2);
  endproperty
  a_free: assert property (p_free) else $error("fault dropped at wrong time");
  property p_shown;
    st_rd && fault_pin_oe |=> reg_rdata[0] || reg_rdata[1] || reg_rdata[3];
  endproperty
  a_shown: assert property (p_shown) else $error("latched flag not read");
endmodule
`default_nettype wire

// *** bench/tone_keying_and_diag_control_bench.sv ***
`default_nettype none
module tone_keying_and_diag_control_bench
  import tone_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic sense = 1'b0;
  logic [6:0] cause = 7'h00;
  logic uvlo = 1'b0;
  logic tone_out;
  logic tone_active;
  logic filter_bypass_drive;
  logic [3:0] vout_sel;
  logic low_drop_select;
  int miscompares = 0;
  int n_compared = 0;
  tone_if link();
  tone_device tone_device_i (.pclk, .presetn, .link(link.dev), .tone_sense_input(sense),
    .overload_cause(cause[0]), .overtemp_cause(cause[1]), .power_bad_cause(cause[2]),
    .output_low_cause(cause[3]), .tone_quality_cause(cause[4]), .min_load_cause(cause[5]),
    .pulldown_oc_cause(cause[6]), .uvlo, .tone_out, .tone_active, .filter_bypass_drive, .vout_sel,
    .low_drop_select);
  tone_host tone_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .link(link.host));
  tone_checker tone_checker_i (.pclk, .presetn, .tone_keying_input(link.tone_keying_input),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
    .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack), .fault_pin_o(link.fault_pin_o),
    .fault_pin_oe(link.fault_pin_oe), .fault_pin_level(link.fault_pin_level),
    .detected_data_output(link.detected_data_output));
  always #10 pclk = ~pclk;
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic expire(input logic bad);
    if (bad) begin
      miscompares++;
      $display("MISMATCH wait expected done seen timeout");
      give_verdict();
    end
  endtask
  // Released on the pready edge, so the next setup waits one edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    expire(pready !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic dev(input logic r, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] s;
    int n;
    wr(OFF_CMD, {21'h0, r, a, d});
    n = 0;
    do begin
      rd(OFF_STAT, s);
      n++;
    end while (s[STAT_BUSY] !== 1'b0 && n < 20);
    expire(s[STAT_BUSY] !== 1'b0);
    q = s[15:8];
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return tone_active;
      1: return tone_out;
      2: return link.tone_keying_input;
      default: return link.detected_data_output;
    endcase
  endfunction
  task automatic wait_for(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(negedge pclk);
      n++;
    end
    expire(pick(k) !== v);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [7:0] q;
    logic [31:0] r;
    logic e;
    dev(1'b0, DEV_DATA1, 8'h0A, q);
    check("vout_sel", 32'hA, 32'(vout_sel));
    dev(1'b1, DEV_DATA1, 8'h00, q);
    check("data1", 32'h0A, 32'(q));
    apb(1'b0, 8'h40, 32'h0, r, e);
    check("unmapped", 32'h1, 32'(e));
    uvlo <= 1'b1;
    dev(1'b0, DEV_DATA1, 8'h05, q);
    check("lockout vout_sel", 32'h0, 32'(vout_sel));
    dev(1'b1, DEV_DATA1, 8'h00, q);
    check("lockout read", 32'h0, 32'(q));
    uvlo <= 1'b0;
    dev(1'b0, DEV_DATA1, 8'h0F, q);
    check("vout_sel top", 32'hF, 32'(vout_sel));
  endtask
  task automatic t_envelope();
    logic [7:0] q;
    int n;
    dev(1'b0, DEV_DATA2, 8'h01, q);
    wr(OFF_KEY, 32'h1);
    wait_for(0, 1'b1, ENV_ON_CYC + 20, n);
    check("env start", 32'h1, 32'(n >= ENV_ON_CYC && n <= ENV_ON_CYC + 8));
    check("bypass on", 32'h1, 32'(filter_bypass_drive));
    wait_for(1, ~tone_out, HALF_CYC + 10, n);
    wait_for(1, ~tone_out, HALF_CYC + 10, n);
    check("env half period", 32'h1, 32'(n >= HALF_CYC - 1 && n <= HALF_CYC + 1));
    wr(OFF_KEY, 32'h0);
    wait_for(0, 1'b0, ENV_OFF_CYC + 20, n);
    check("env stop", 32'h1, 32'(n >= ENV_OFF_CYC && n <= ENV_OFF_CYC + 8));
    check("bypass off", 32'h0, 32'(filter_bypass_drive));
    wr(OFF_KEY, 32'h1);
    wait_for(0, 1'b1, ENV_ON_CYC + 20, n);
    repeat (2 * ENV_OFF_CYC) @(negedge pclk);
    check("continuous", 32'h1, 32'(tone_active));
    dev(1'b0, DEV_DATA2, 8'h00, q);
    wait_for(0, 1'b0, 10, n);
    wr(OFF_KEY, 32'h0);
  endtask
  task automatic t_external();
    logic [7:0] q;
    int n;
    dev(1'b0, DEV_DATA2, 8'h03, q);
    wr(OFF_KEY, 32'h2);
    wait_for(2, 1'b1, 2 * HALF_CYC + 10, n);
    wait_for(0, 1'b1, EXT_ON_CYC + 20, n);
    check("ext start", 32'h1, 32'(n >= EXT_ON_CYC && n <= EXT_ON_CYC + 8));
    wait_for(2, 1'b0, HALF_CYC + 10, n);
    wait_for(2, 1'b1, HALF_CYC + 10, n);
    wait_for(1, 1'b1, 8, n);
    wait_for(2, 1'b0, HALF_CYC + 10, n);
    wait_for(1, 1'b0, 8, n);
    wr(OFF_KEY, 32'h0);
    wait_for(0, 1'b0, EXT_OFF_CYC + 20, n);
    check("ext stop", 32'h1, 32'(n + HALF_CYC + 8 >= EXT_OFF_CYC));
    dev(1'b0, DEV_DATA2, 8'h05, q);
    check("low drop forced", 32'h0, 32'(low_drop_select));
    dev(1'b0, DEV_DATA2, 8'h04, q);
    check("low drop set", 32'h1, 32'(low_drop_select));
    dev(1'b0, DEV_DATA2, 8'h00, q);
  endtask
  task automatic t_fault();
    logic [7:0] q;
    int b;
    wr(OFF_IRQ_EN, 32'h2);
    for (int i = 0; i < 3; i++) begin
      b = (i == 2) ? 3 : i;
      cause[i] <= 1'b1;
      repeat (4) @(posedge pclk);
      cause[i] <= 1'b0;
      repeat (8) @(negedge pclk);
      check("fault line", 32'h0, 32'(link.fault_pin_level));
      check("fault irq", 32'h1, 32'(irq));
      dev(1'b1, DEV_STAT1, 8'h00, q);
      check("latched", 32'(1 << b), 32'(q));
      dev(1'b1, DEV_STAT1, 8'h00, q);
      check("cleared", 32'h0, 32'(q));
      check("fault line free", 32'h1, 32'(link.fault_pin_level));
      wr(OFF_IRQ_CLR, 32'h2);
      repeat (3) @(posedge pclk);
      check("irq cleared", 32'h0, 32'(irq));
    end
    cause[1] <= 1'b1;
    dev(1'b1, DEV_STAT1, 8'h00, q);
    dev(1'b1, DEV_STAT1, 8'h00, q);
    check("persisting", 32'h2, 32'(q));
    check("fault line held", 32'h0, 32'(link.fault_pin_level));
    cause[1] <= 1'b0;
    dev(1'b1, DEV_STAT1, 8'h00, q);
    check("last latched", 32'h2, 32'(q));
    dev(1'b1, DEV_STAT1, 8'h00, q);
    check("now clear", 32'h0, 32'(q));
    wr(OFF_IRQ_CLR, 32'h7);
  endtask
  task automatic t_live();
    logic [7:0] q;
    cause[6:3] <= 4'hF;
    dev(1'b1, DEV_STAT1, 8'h00, q);
    check("status1 live", 32'h04, 32'(q));
    dev(1'b1, DEV_STAT2, 8'h00, q);
    check("status2 live", 32'h07, 32'(q));
    cause[6:3] <= 4'h0;
    dev(1'b1, DEV_STAT1, 8'h00, q);
    check("status1 idle", 32'h0, 32'(q));
    dev(1'b1, DEV_STAT2, 8'h00, q);
    check("status2 idle", 32'h0, 32'(q));
  endtask
  task automatic t_detect();
    logic [7:0] q;
    logic [31:0] s;
    int n;
    for (int i = 0; i < 8; i++) begin
      sense <= ~sense;
      repeat (20) @(posedge pclk);
    end
    check("detected out", 32'h1, 32'(link.detected_data_output));
    rd(OFF_STAT, s);
    check("host detect", 32'h1, 32'(s[STAT_DDATA]));
    dev(1'b1, DEV_STAT2, 8'h00, q);
    check("presence", 32'h08, 32'(q));
    rd(OFF_IRQ_ST, s);
    check("detect event", 32'h1, 32'(s[IRQ_DDATA]));
    wait_for(3, 1'b0, DET_HOLD_CYC + 20, n);
    dev(1'b1, DEV_STAT2, 8'h00, q);
    check("presence gone", 32'h0, 32'(q));
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_envelope();
    t_external();
    t_fault();
    t_live();
    t_detect();
    give_verdict();
  end
endmodule
`default_nettype wire
